// ==== common/pmc_consts.vh ====
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH
// register indices (byte address = 4 * index)
`define PMC_IDX_DLL        12'h446
`define PMC_IDX_ESD        12'h448
`define PMC_IDX_LEDCFG1    12'h460
`define PMC_IDX_IMP        12'h461
`define PMC_IDX_IOC1       12'h462
`define PMC_IDX_IOC2       12'h463
`define PMC_IDX_STRAP      12'h467
`define PMC_IDX_LEDCFG2    12'h469
`define PMC_IDX_BMSR       12'h001
// reset values
`define PMC_RST_DLL        16'h0077
`define PMC_RST_LEDCFG1    16'h2610
`define PMC_RST_IMP        16'h0410
`define PMC_RST_IOC1       16'h0000
`define PMC_RST_IOC2       16'h0001
// writable masks
`define PMC_WM_DLL         16'h00FF
`define PMC_WM_LEDCFG1     16'hFFFF
`define PMC_WM_IMP         16'hFFFF
`define PMC_WM_IOC1        16'h7777
`define PMC_WM_IOC2        16'h00F7
`define PMC_WM_LEDCFG2     16'h0777
// indicator sources
`define PMC_SRC_LINK       4'h0
`define PMC_SRC_LINK_ACT   4'h1
`define PMC_SRC_LINK_TX    4'h2
`define PMC_SRC_MASTER     4'h4
`define PMC_SRC_SLAVE      4'h5
`define PMC_SRC_ACT        4'h6
`define PMC_SRC_LOST       4'h9
`define PMC_SRC_TEST_PATTERN_CHECKER       4'hA
// pin functions
`define PMC_FN_IND         3'h0
`define PMC_FN_CLK         3'h1
`define PMC_FN_WAKE        3'h2
`define PMC_FN_UV          3'h3
`define PMC_FN_TS_TX       3'h4
`define PMC_FN_TS_RX       3'h5
`define PMC_FN_ZERO        3'h6
// blink periods in ms and cycle counts at 250 MHz
`define PMC_CLK_MHZ        250
`define PMC_MS_CYC         (`PMC_CLK_MHZ * 1000)
`define PMC_BLINK_MS0      50
`define PMC_BLINK_MS1      100
`define PMC_BLINK_MS2      200
`define PMC_BLINK_MS3      500
`endif

// ==== rtl/pmc_regs.v ====
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.vh"
module pmc_regs #(
	parameter BLINK_SCALE = `PMC_MS_CYC
) (
	// clock and reset
	input  wire        CLK,
	input  wire        SYS_RST,
	input  wire        PWR_ON_RST,
	// wishbone slave
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [13:0] WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	// status inputs from the phy core and pins
	input  wire        LINK_UP,
	input  wire        RX_ACT,
	input  wire        TX_ACT,
	input  wire        ROLE_MASTER,
	input  wire        TEST_PATTERN_CHECKER_ERR,
	input  wire        TEST_PATTERN_CHECKER_CNT_CLR,
	input  wire        MAC_ESD_HIT,
	input  wire        LINE_ESD_HIT,
	input  wire [15:0] STRAP_PINS,
	input  wire        CRYSTAL_INPUT_CLOCK,
	input  wire        TRANSMIT_SYMBOL_CLOCK,
	input  wire        WAKE_IND,
	input  wire        UV_IND,
	input  wire        TS_TX_EVT,
	input  wire        TS_RX_EVT,
	// configuration outputs
	output reg  [3:0]  TX_DELAY_CODE,
	output reg  [3:0]  RX_DELAY_CODE,
	output reg  [3:0]  MAC_IMP_CODE,
	output reg  [15:0] STRAP_CAPTURE,
	// pins
	output reg         INDICATOR_PIN_0,
	output reg         INDICATOR_PIN_1,
	output reg         CLOCK_OUTPUT_PIN
);

	// register storage
	reg  [15:0] dll_ff;            // delay line control
	reg  [15:0] ledcfg1_ff;        // indicator sources and blink
	reg  [15:0] imp_ff;            // mac impedance
	reg  [15:0] ioc1_ff;           // pin function 1
	reg  [15:0] ioc2_ff;           // pin function 2
	reg  [15:0] ledcfg2_ff;        // override/polarity
	reg  [5:0]  mac_esd_ff;        // mac-side discharge count
	reg  [5:0]  line_esd_ff;       // line-side discharge count
	reg         lost_ff;           // latched link loss
	reg         link_q_ff;         // link delayed for edge
	reg         test_pattern_checker_ff;           // latched checker error
	reg  [27:0] blink_cnt_ff;      // blink divider
	reg         blink_ff;          // blink phase
	reg         strap_done_ff;     // strap taken once
	// synchronisers for outside inputs
	reg  [15:0] strap_s1_ff;
	reg  [15:0] strap_s2_ff;
	reg  [7:0]  in_s1_ff;
	reg  [7:0]  in_s2_ff;
	// bus decode
	wire        req;
	wire [11:0] idx;
	wire        wr;
	wire [15:0] wdat;
	reg  [15:0] rdat;
	reg  [27:0] blink_lim;
	reg  [2:0]  ind;
	reg  [2:0]  ind_pin;
	reg         nxt_pin0;
	reg         nxt_pin1;
	reg         nxt_clko;
	wire        bmsr_read;
	integer     i;
	localparam integer blink_end0 = `PMC_BLINK_MS0 * BLINK_SCALE / 2 - 1; // last count of a half
	localparam integer blink_end1 = `PMC_BLINK_MS1 * BLINK_SCALE / 2 - 1;
	localparam integer blink_end2 = `PMC_BLINK_MS2 * BLINK_SCALE / 2 - 1;
	localparam integer blink_end3 = `PMC_BLINK_MS3 * BLINK_SCALE / 2 - 1;

	assign req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign idx  = WB_ADR_I[13:2];
	assign wr   = req & WB_WE_I & WB_SEL_I[0] & WB_SEL_I[1];
	assign wdat = WB_DAT_I[15:0];

	// pin inputs through two flops before use
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			in_s1_ff    <= 8'h00;
			in_s2_ff    <= 8'h00;
		end
		else
		begin
			in_s1_ff    <= {TRANSMIT_SYMBOL_CLOCK, WAKE_IND, UV_IND, TS_TX_EVT, TS_RX_EVT,
				MAC_ESD_HIT, LINE_ESD_HIT, CRYSTAL_INPUT_CLOCK};
			in_s2_ff    <= in_s1_ff;
		end
	end

	// straps track the pins through reset, so the capture sees settled levels
	always @(posedge CLK)
	begin
		strap_s1_ff <= STRAP_PINS;
		strap_s2_ff <= strap_s1_ff;
	end

	// discharge counters: only the power-up reset clears them, so a
	// system reset keeps the history; every hit cycle counts
	always @(posedge CLK or posedge PWR_ON_RST)
	begin
		if (PWR_ON_RST)
		begin
			mac_esd_ff  <= 6'h00;
			line_esd_ff <= 6'h00;
		end
		else
		begin
			if (in_s2_ff[2])
				mac_esd_ff <= mac_esd_ff + 6'h01;
			if (in_s2_ff[1])
				line_esd_ff <= line_esd_ff + 6'h01;
		end
	end

	// read mux; strap and esd are read-only
	always @*
	begin
		case (idx)
			`PMC_IDX_DLL:     rdat = dll_ff;
			`PMC_IDX_ESD:     rdat = {2'b00, mac_esd_ff, 2'b00, line_esd_ff};
			`PMC_IDX_LEDCFG1: rdat = ledcfg1_ff;
			`PMC_IDX_IMP:     rdat = imp_ff;
			`PMC_IDX_IOC1:    rdat = ioc1_ff;
			`PMC_IDX_IOC2:    rdat = ioc2_ff;
			`PMC_IDX_STRAP:   rdat = STRAP_CAPTURE;
			`PMC_IDX_LEDCFG2: rdat = ledcfg2_ff;
			default:          rdat = 16'h0000;
		endcase
	end

	// a read of basic status over this bus releases the link-loss latch
	assign bmsr_read = req & ~WB_WE_I & (idx == `PMC_IDX_BMSR);

	// bus slave and writable registers; one wait-free ack per request
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			WB_ACK_O   <= 1'b0;
			WB_DAT_O   <= 32'h00000000;
			dll_ff     <= `PMC_RST_DLL;
			ledcfg1_ff <= `PMC_RST_LEDCFG1;
			imp_ff     <= `PMC_RST_IMP;
			ioc1_ff    <= `PMC_RST_IOC1;
			ioc2_ff    <= `PMC_RST_IOC2;
			ledcfg2_ff <= 16'h0000;
		end
		else
		begin
			WB_ACK_O <= req;
			WB_DAT_O <= {16'h0000, rdat};
			if (wr)
			begin
				// masked writes keep read-only bits at their defaults
				case (idx)
					`PMC_IDX_DLL:
						dll_ff <= wdat & `PMC_WM_DLL;
					`PMC_IDX_LEDCFG1:
						ledcfg1_ff <= wdat;
					`PMC_IDX_IMP:
						imp_ff <= wdat;
					`PMC_IDX_IOC1:
						ioc1_ff <= wdat & `PMC_WM_IOC1;
					`PMC_IDX_IOC2:
						ioc2_ff <= wdat & `PMC_WM_IOC2;
					`PMC_IDX_LEDCFG2:
						ledcfg2_ff <= wdat & `PMC_WM_LEDCFG2;
					default: ;
				endcase
			end
			// polarity bits of indicators 0 and 1 take the inverted strap value once at release
			if (~strap_done_ff)
			begin
				ledcfg2_ff[2] <= ~strap_s2_ff[8];
				ledcfg2_ff[6] <= ~strap_s2_ff[14];
			end
		end
	end

	// strap capture one pass after reset release
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			strap_done_ff <= 1'b0;
			STRAP_CAPTURE <= 16'h0000;
		end
		else if (~strap_done_ff)
		begin
			strap_done_ff <= 1'b1;
			STRAP_CAPTURE <= strap_s2_ff;
		end
	end

	// latches: set wins over clear
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			lost_ff   <= 1'b0;
			link_q_ff <= 1'b0;
			test_pattern_checker_ff   <= 1'b0;
		end
		else
		begin
			link_q_ff <= LINK_UP;
			if (link_q_ff & ~LINK_UP)
				lost_ff <= 1'b1;
			else if (bmsr_read)
				lost_ff <= 1'b0;
			if (TEST_PATTERN_CHECKER_ERR)
				test_pattern_checker_ff <= 1'b1;
			else if (TEST_PATTERN_CHECKER_CNT_CLR)
				test_pattern_checker_ff <= 1'b0;
		end
	end

	// last count of the half period for the selected rate
	always @*
	begin
		case (ledcfg1_ff[13:12])
			2'b00:   blink_lim = blink_end0[27:0];
			2'b01:   blink_lim = blink_end1[27:0];
			2'b10:   blink_lim = blink_end2[27:0];
			default: blink_lim = blink_end3[27:0];
		endcase
	end

	// blink divider: phase toggles each half period
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			blink_cnt_ff <= 28'h0000000;
			blink_ff     <= 1'b0;
		end
		else if (blink_cnt_ff >= blink_lim)
		begin
			blink_cnt_ff <= 28'h0000000;
			blink_ff     <= ~blink_ff;
		end
		else
			blink_cnt_ff <= blink_cnt_ff + 28'h0000001;
	end

	// indicator source decode, same table for all three
	function ind_src;
		input [3:0] sel;
		begin
			case (sel)
				`PMC_SRC_LINK:     ind_src = LINK_UP;
				`PMC_SRC_LINK_ACT: ind_src = LINK_UP & (RX_ACT | TX_ACT) & blink_ff;
				`PMC_SRC_LINK_TX:  ind_src = LINK_UP & TX_ACT & blink_ff;
				`PMC_SRC_MASTER:   ind_src = LINK_UP & ROLE_MASTER;
				`PMC_SRC_SLAVE:    ind_src = LINK_UP & ~ROLE_MASTER;
				`PMC_SRC_ACT:      ind_src = (RX_ACT | TX_ACT) & blink_ff;
				`PMC_SRC_LOST:     ind_src = lost_ff;
				`PMC_SRC_TEST_PATTERN_CHECKER:     ind_src = test_pattern_checker_ff;
				default:           ind_src = 1'b0;
			endcase
		end
	endfunction

	// indicator levels after override and polarity
	always @*
	begin
		for (i = 0; i < 3; i = i + 1)
		begin
			ind[i] = ind_src(ledcfg1_ff[4*i +: 4]);
			ind_pin[i] = ledcfg2_ff[4*i] ? ledcfg2_ff[4*i+1] :
				(ledcfg2_ff[4*i+2] ? ind[i] : ~ind[i]);
		end
	end

	// eight-way pin function
	function pin_fn;
		input [2:0] fn;
		input       ind_lvl;
		input       clk_lvl;
		begin
			case (fn)
				`PMC_FN_IND:   pin_fn = ind_lvl;
				`PMC_FN_CLK:   pin_fn = clk_lvl;
				`PMC_FN_WAKE:  pin_fn = in_s2_ff[6];
				`PMC_FN_UV:    pin_fn = in_s2_ff[5];
				`PMC_FN_TS_TX: pin_fn = in_s2_ff[4];
				`PMC_FN_TS_RX: pin_fn = in_s2_ff[3];
				`PMC_FN_ZERO:  pin_fn = 1'b0;
				default:       pin_fn = 1'b1;
			endcase
		end
	endfunction

	// pin muxes; clocks are sampled, so this is a registered copy
	always @*
	begin
		nxt_pin0 = pin_fn(ioc1_ff[2:0], ind_pin[0],
			ioc1_ff[6:4] == 3'h1 ? in_s2_ff[7] : in_s2_ff[0]);
		nxt_pin1 = pin_fn(ioc1_ff[10:8], ind_pin[1],
			ioc1_ff[14:12] == 3'h1 ? in_s2_ff[7] : in_s2_ff[0]);
		nxt_clko = pin_fn(ioc2_ff[2:0], ind_pin[2],
			ioc2_ff[7:4] == 4'h1 ? in_s2_ff[7] : in_s2_ff[0]);
	end

	// registered outputs
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			INDICATOR_PIN_0  <= 1'b0;
			INDICATOR_PIN_1  <= 1'b0;
			CLOCK_OUTPUT_PIN <= 1'b0;
			TX_DELAY_CODE    <= 4'h7;
			RX_DELAY_CODE    <= 4'h7;
			MAC_IMP_CODE     <= 4'h8;
		end
		else
		begin
			INDICATOR_PIN_0  <= nxt_pin0;
			INDICATOR_PIN_1  <= nxt_pin1;
			CLOCK_OUTPUT_PIN <= nxt_clko;
			TX_DELAY_CODE    <= dll_ff[7:4];
			RX_DELAY_CODE    <= dll_ff[3:0];
			MAC_IMP_CODE     <= imp_ff[4:1];
		end
	end

endmodule
`default_nettype wire

// ==== tb/pmc_regs_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.vh"
module pmc_regs_asserts (
	// clock and reset
	input wire logic        CLK,
	input wire logic        SYS_RST,
	// register bus
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [13:0] WB_ADR_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	// configuration outputs
	input wire logic [3:0]  TX_DELAY_CODE,
	input wire logic [3:0]  RX_DELAY_CODE,
	input wire logic [3:0]  MAC_IMP_CODE,
	input wire logic [15:0] STRAP_CAPTURE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// request taken at this edge
	wire        take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	// only a write covering both low bytes lands
	wire        wr16 = take & WB_WE_I & WB_SEL_I[0] & WB_SEL_I[1];
	wire [11:0] idx  = WB_ADR_I[13:2];
	ack_timing_a: assert property (take |=> WB_ACK_O) else $error("ack late");
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
	ack_cause_a: assert property (WB_ACK_O |-> $past(take)) else $error("stray ack");
	upper_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
		else $error("upper half set");
	unmapped_zero_a: assert property (take && !WB_WE_I && idx == 12'h450 |=> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	strap_read_a: assert property (take && !WB_WE_I && idx == `PMC_IDX_STRAP
		|=> WB_DAT_O[15:0] == STRAP_CAPTURE) else $error("strap read mismatch");
	strap_hold_a: assert property (!$past(SYS_RST) && !$past(SYS_RST, 2)
		|-> $stable(STRAP_CAPTURE)) else $error("strap capture moved");
	delay_write_a: assert property (wr16 && idx == `PMC_IDX_DLL
		|-> ##2 {TX_DELAY_CODE, RX_DELAY_CODE} == $past(WB_DAT_I[7:0], 2))
		else $error("delay codes not written");
	imp_write_a: assert property (wr16 && idx == `PMC_IDX_IMP
		|-> ##2 MAC_IMP_CODE == $past(WB_DAT_I[4:1], 2)) else $error("impedance not written");
	reset_codes_a: assert property ($past(SYS_RST)
		|-> TX_DELAY_CODE == 4'h7 && RX_DELAY_CODE == 4'h7 && MAC_IMP_CODE == 4'h8)
		else $error("bad reset codes");
endmodule
bind pmc_regs pmc_regs_asserts u_chk (.CLK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
	.WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .TX_DELAY_CODE,
	.RX_DELAY_CODE, .MAC_IMP_CODE, .STRAP_CAPTURE);
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.vh"
module tb;
	// bench-driven inputs
	logic        CLK = 0, SYS_RST = 1, PWR_ON_RST = 1, WB_CYC_I = 0, WB_STB_I = 0;
	logic        WB_WE_I = 0, LINK_UP = 1, RX_ACT = 0, TX_ACT = 0, ROLE_MASTER = 0;
	logic        TEST_PATTERN_CHECKER_ERR = 0, TEST_PATTERN_CHECKER_CNT_CLR = 0, MAC_ESD_HIT = 0, LINE_ESD_HIT = 0;
	logic        CRYSTAL_INPUT_CLOCK = 1, TRANSMIT_SYMBOL_CLOCK = 0, WAKE_IND = 1;
	logic        UV_IND = 0, TS_TX_EVT = 1, TS_RX_EVT = 0;
	logic [13:0] WB_ADR_I = 0;
	logic [3:0]  WB_SEL_I = 0;
	logic [31:0] WB_DAT_I = 0;
	// board straps keep receive data 3 in mode 00
	logic [15:0] STRAP_PINS = 16'hE4B0;
	// design outputs
	wire  [31:0] WB_DAT_O;
	wire         WB_ACK_O, INDICATOR_PIN_0, INDICATOR_PIN_1, CLOCK_OUTPUT_PIN;
	wire  [3:0]  TX_DELAY_CODE, RX_DELAY_CODE, MAC_IMP_CODE;
	wire  [15:0] STRAP_CAPTURE;
	logic [15:0] rd;
	int          errors = 0, n_compared = 0;
	int          hp;
	// register table: index, reset value, writable bits
	logic [11:0] ix_t [9] = '{`PMC_IDX_DLL, `PMC_IDX_ESD, `PMC_IDX_LEDCFG1, `PMC_IDX_IMP,
		`PMC_IDX_IOC1, `PMC_IDX_IOC2, `PMC_IDX_STRAP, `PMC_IDX_LEDCFG2, 12'h450};
	logic [15:0] rs_t [9] = '{16'h0077, 0, 16'h2610, 16'h0410, 0, 16'h0001, 16'hE4B0, 16'h0004, 0};
	logic [15:0] wm_t [9] = '{16'h00FF, 0, 16'hFFFF, 16'hFFFF, 16'h7777, 16'h00F7, 0, 16'h0777, 0};
	// pin level per function code with the inputs held above
	logic [7:0]  fx = 8'h96;
	// a tiny blink scale keeps the run short
	localparam int blink_scale = 2;
	pmc_regs #(.BLINK_SCALE(blink_scale)) DUT (.CLK, .SYS_RST, .PWR_ON_RST, .WB_CYC_I, .WB_STB_I,
		.WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .LINK_UP, .RX_ACT,
		.TX_ACT, .ROLE_MASTER, .TEST_PATTERN_CHECKER_ERR, .TEST_PATTERN_CHECKER_CNT_CLR, .MAC_ESD_HIT, .LINE_ESD_HIT,
		.STRAP_PINS, .CRYSTAL_INPUT_CLOCK, .TRANSMIT_SYMBOL_CLOCK, .WAKE_IND, .UV_IND,
		.TS_TX_EVT, .TS_RX_EVT, .TX_DELAY_CODE, .RX_DELAY_CODE, .MAC_IMP_CODE,
		.STRAP_CAPTURE, .INDICATOR_PIN_0, .INDICATOR_PIN_1, .CLOCK_OUTPUT_PIN);
	// 250 MHz clock
	initial
		forever #2 CLK = ~CLK;
	task automatic give_verdict;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask
	// cycles between two level changes of indicator pin 0, after one change to align
	task automatic half_period(output int n);
		logic v;
		n = 0;
		v = INDICATOR_PIN_0;
		while (INDICATOR_PIN_0 === v && n < 4000)
		begin
			@(posedge CLK);
			n++;
		end
		v = INDICATOR_PIN_0;
		n = 0;
		while (INDICATOR_PIN_0 === v && n < 4000)
		begin
			@(posedge CLK);
			n++;
		end
	endtask
	// one classic cycle; held until ack is sampled high
	task automatic bus(input logic we, input logic [11:0] ix, input logic [15:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		WB_CYC_I <= 1;
		WB_STB_I <= 1;
		WB_WE_I <= we;
		WB_ADR_I <= {ix, 2'b00};
		WB_SEL_I <= s;
		WB_DAT_I <= {16'h0, d};
		do
			@(posedge CLK);
		while (WB_ACK_O !== 1'b1 && ++n < 100);
		if (n >= 100)
			errors++;
		rd = WB_DAT_O[15:0];
		WB_CYC_I <= 0;
		WB_STB_I <= 0;
		@(posedge CLK);
	endtask
	// pins as {pin 1, pin 0, clock-out}
	function automatic logic [15:0] pins();
		return {13'h0, INDICATOR_PIN_1, INDICATOR_PIN_0, CLOCK_OUTPUT_PIN};
	endfunction
	// watchdog well beyond the expected run
	initial
	begin
		#40000;
		errors++;
		give_verdict();
	end
	initial
	begin
		cyc(10);
		SYS_RST <= 0;
		PWR_ON_RST <= 0;
		cyc(3);
		chk("strap", STRAP_CAPTURE, 16'hE4B0);
		// reset values, full write, then a partial-lane write that must be dropped
		for (int i = 0; i < 9; i++)
		begin
			bus(0, ix_t[i], 0, 4'hF);
			chk("reset", rd, rs_t[i]);
			bus(1, ix_t[i], 16'hFFFF, 4'hF);
			bus(1, ix_t[i], 16'h0000, 4'h1);
			bus(0, ix_t[i], 0, 4'hF);
			chk("write", rd, rs_t[i] & ~wm_t[i] | wm_t[i]);
		end
		chk("codes", {4'h0, TX_DELAY_CODE, RX_DELAY_CODE, MAC_IMP_CODE}, 16'h0FFF);
		// every non-indicator function on all three pins
		for (int f = 1; f < 8; f++)
		begin
			bus(1, `PMC_IDX_IOC1, {5'h0, f[2:0], 5'h0, f[2:0]}, 4'hF);
			bus(1, `PMC_IDX_IOC2, {13'h0, f[2:0]}, 4'hF);
			cyc(8);
			chk("function", pins(), {13'h0, {3{fx[f]}}});
		end
		// transmit symbol clock chosen instead of the crystal
		bus(1, `PMC_IDX_IOC1, 16'h1111, 4'hF);
		bus(1, `PMC_IDX_IOC2, 16'h0011, 4'hF);
		cyc(8);
		chk("clock select", pins(), 0);
		// override wins even with active-low polarity
		bus(1, `PMC_IDX_IOC1, 0, 4'hF);
		bus(1, `PMC_IDX_LEDCFG2, 16'h0033, 4'hF);
		cyc(8);
		chk("force high", pins() >> 1, 3);
		bus(1, `PMC_IDX_LEDCFG2, 16'h0011, 4'hF);
		cyc(8);
		chk("force low", pins() >> 1, 0);
		// link source, then the link-lost latch and its clear by a status read
		bus(1, `PMC_IDX_LEDCFG2, 16'h0004, 4'hF);
		bus(1, `PMC_IDX_LEDCFG1, 16'h2600, 4'hF);
		cyc(8);
		chk("link", INDICATOR_PIN_0, 1);
		bus(1, `PMC_IDX_LEDCFG1, 16'h2609, 4'hF);
		cyc(8);
		chk("no loss", INDICATOR_PIN_0, 0);
		LINK_UP <= 0;
		cyc(3);
		LINK_UP <= 1;
		cyc(8);
		chk("loss held", INDICATOR_PIN_0, 1);
		bus(0, `PMC_IDX_BMSR, 0, 4'hF);
		cyc(8);
		chk("loss cleared", INDICATOR_PIN_0, 0);
		// checker error on all three indicators; 1 and 2 are active low here
		bus(1, `PMC_IDX_IOC2, 0, 4'hF);
		bus(1, `PMC_IDX_LEDCFG1, 16'h2AAA, 4'hF);
		cyc(8);
		chk("no error", pins(), 5);
		TEST_PATTERN_CHECKER_ERR <= 1;
		cyc(1);
		TEST_PATTERN_CHECKER_ERR <= 0;
		cyc(8);
		chk("error held", pins(), 2);
		// an error in the clearing cycle keeps the latch set
		TEST_PATTERN_CHECKER_ERR <= 1;
		TEST_PATTERN_CHECKER_CNT_CLR <= 1;
		cyc(1);
		TEST_PATTERN_CHECKER_ERR <= 0;
		TEST_PATTERN_CHECKER_CNT_CLR <= 0;
		cyc(8);
		chk("set beats clear", pins(), 2);
		TEST_PATTERN_CHECKER_CNT_CLR <= 1;
		cyc(1);
		TEST_PATTERN_CHECKER_CNT_CLR <= 0;
		cyc(8);
		chk("error cleared", pins(), 5);
		// activity blinks at the selected rate; half periods counted in cycles
		RX_ACT <= 1;
		bus(1, `PMC_IDX_LEDCFG1, 16'h0006, 4'hF);
		cyc(8);
		half_period(hp);
		chk("blink 50 ms", hp, `PMC_BLINK_MS0 * blink_scale / 2);
		bus(1, `PMC_IDX_LEDCFG1, 16'h3006, 4'hF);
		cyc(8);
		half_period(hp);
		chk("blink 500 ms", hp, `PMC_BLINK_MS3 * blink_scale / 2);
		RX_ACT <= 0;
		// every high cycle counts; a system reset keeps the counts
		MAC_ESD_HIT <= 1;
		LINE_ESD_HIT <= 1;
		cyc(2);
		LINE_ESD_HIT <= 0;
		cyc(1);
		MAC_ESD_HIT <= 0;
		cyc(6);
		bus(0, `PMC_IDX_ESD, 0, 4'hF);
		chk("esd", rd, 16'h0302);
		SYS_RST <= 1;
		cyc(2);
		SYS_RST <= 0;
		cyc(3);
		bus(0, `PMC_IDX_ESD, 0, 4'hF);
		chk("esd kept", rd, 16'h0302);
		PWR_ON_RST <= 1;
		cyc(2);
		PWR_ON_RST <= 0;
		cyc(3);
		bus(0, `PMC_IDX_ESD, 0, 4'hF);
		chk("esd cleared", rd, 0);
		give_verdict();
	end
endmodule
`default_nettype wire
